// *** host_model.sv ***
// host side bus master for the register port
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] addr,
	output logic [15:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [15:0] rdata
);
	initial begin
		addr = 8'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : put
	// data stands only in the cycle after the strobe
	task automatic get(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : get
endmodule : host_model

// *** ident_pkg.sv ***
// constants for the identification word block
package ident_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned STR_SERIAL_W = 10;
	localparam int unsigned STR_FW_W = 4;
	localparam int unsigned STR_MODEL_W = 20;
	// word indices
	localparam logic [7:0] W_CONFIG = 8'h00;
	localparam logic [7:0] W_SERIAL = 8'h0a;
	localparam logic [7:0] W_FW = 8'h17;
	localparam logic [7:0] W_MODEL = 8'h1b;
	localparam logic [7:0] W_MULT_MAX = 8'h2f;
	localparam logic [7:0] W_TRUSTED = 8'h30;
	localparam logic [7:0] W_CAP0 = 8'h31;
	localparam logic [7:0] W_CAP1 = 8'h32;
	localparam logic [7:0] W_VALID = 8'h35;
	localparam logic [7:0] W_SANITIZE = 8'h3b;
	localparam logic [7:0] W_SECT_LO = 8'h3c;
	localparam logic [7:0] W_SECT_HI = 8'h3d;
	localparam logic [7:0] W_MDMA = 8'h3f;
	localparam logic [7:0] W_PIO = 8'h40;
	localparam logic [7:0] W_MDMA_MIN = 8'h41;
	localparam logic [7:0] W_MDMA_REC = 8'h42;
	localparam logic [7:0] W_PIO_MIN = 8'h43;
	localparam logic [7:0] W_PIO_RDY = 8'h44;
	localparam logic [7:0] W_ADDL = 8'h45;
	localparam logic [7:0] W_QUEUE = 8'h4b;
	// fixed word values
	localparam logic [15:0] V_MULT_MAX = 16'h8010;
	localparam logic [15:0] V_TRUSTED = 16'h4001;
	localparam logic [15:0] V_CAP0 = 16'h2f00;
	localparam logic [15:0] V_CAP1 = 16'h4001;
	localparam logic [15:0] V_VALID = 16'h0006;
	localparam logic [15:0] V_SANITIZE_FIX = 16'he000;
	localparam logic [15:0] V_MDMA_SUP = 16'h0007;
	localparam logic [15:0] V_PIO = 16'h0003;
	localparam logic [15:0] V_CYCLE = 16'h0078;
	localparam logic [15:0] V_ADDL = 16'h4000;
	localparam logic [15:0] V_QUEUE = 16'h001f;
	// field positions
	localparam int unsigned B_SANITIZE = 12;
	localparam int unsigned B_MULT_VALID = 8;
	localparam int unsigned B_MDMA_SEL = 8;
	// sector counts per capacity
	localparam logic [31:0] SECT_CAP0 = 32'h0df9_4bb0;
	localparam logic [31:0] SECT_CAP1 = 32'h1bf2_44b0;
	localparam logic [31:0] SECT_CAP2 = 32'h37e4_36b0;
	localparam logic [31:0] SECT_CAP3 = 32'h5d26_ceb0;
	// control register reset values
	localparam logic [7:0] RST_MULT = 8'h10;
	localparam logic [2:0] RST_MDMA = 3'h0;
	localparam logic [1:0] RST_CAP = 2'h0;
	// register port addresses
	localparam logic [7:0] R_CTRL = 8'h80;
	localparam logic [7:0] R_STRING = 8'h81;
	localparam logic [7:0] R_STATUS = 8'h82;
	// control and status field positions, string store size and reset word
	localparam int unsigned C_MULT = 0;
	localparam int unsigned C_MDMA = 8;
	localparam int unsigned C_TRUST = 11;
	localparam int unsigned C_CAP = 12;
	localparam int unsigned C_SNAP = 15;
	localparam int unsigned S_STR_IDX = 5;
	localparam int unsigned STR_WORDS = 34;
	localparam logic [7:0] SNAP_PEND = 8'h01;
	localparam logic [15:0] RST_STR = 16'h2020;
endpackage : ident_pkg

// *** ident_string_store.sv ***
// ascii string words: serial, firmware and model
`timescale 1ns/1ps
module ident_string_store (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// access
	string_if.store port
);
	import ident_pkg::*;
	typedef struct packed {
		logic [ident_pkg::STR_WORDS-1:0][15:0] mem;
	} store_s;
	store_s s_q;
	store_s s_d;
	always_comb begin
		s_d = s_q;
		if (port.we && port.waddr < 6'(STR_WORDS)) begin
			s_d.mem[port.waddr] = port.wdata;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{mem: {STR_WORDS{RST_STR}}};
		end else begin
			s_q <= s_d;
		end
	end
	assign port.rdata = (port.raddr < 6'(STR_WORDS)) ? s_q.mem[port.raddr] : RST_STR;
endmodule : ident_string_store

// *** ident_words.sv ***
`timescale 1ns/1ps
// identification data block, words 0 to 75, over a plain register port
// Summary of operation
// - word 47 reads 8010h: 80h upper, max 10h sectors per block
// - word 59 low byte is multiple count from the snapshot, bit 8 flags valid
// - word 48 reads 4001h: bit 14 set, trusted feature supported
// - word 49 bit 13 set: standard standby timer values
// - word 49 sets bits 11,10,9,8; low byte zero
// - word 50 reads 4001h: bit 14 set, bit 0 set
// - word 53 bit 2 set, word 88 valid; upper bits zero
// - word 53 bit 1 set, words 64 to 70 valid
// - word 59 bits 15,14,13 set for erase commands; bits 11-9 zero
// - word 59 bit 12 set unless trusted security mode enabled in the snapshot
// - words 60-61 give sector count of selected capacity, low word first
// - word 63 bits 10,9,8 show dma mode 2,1,0 from the snapshot; reset zero
// - word 63 bits 2,1,0 set; bits 15-11 zero
// - word 64 reads 0003h
// - words 65 and 66 read 0078h
// - words 67 and 68 read 0078h
// - word 69 bit 14 set, bit 15 clear
// - words 10-19 hold the 20-character serial number
// - words 23-26 firmware, words 27-46 model string
// - word 75 reads 001fh
module ident_words (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [ident_pkg::ADDR_W-1:0] addr,
	input wire logic [ident_pkg::WORD_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [ident_pkg::WORD_W-1:0] rdata
);
	import ident_pkg::*;

	typedef struct packed {
		logic [7:0] mult;
		logic [2:0] mdma;
		logic trust;
		logic [1:0] cap;
		logic [5:0] str_idx;
		// snapshot seen by the host
		logic [7:0] snap_mult;
		logic [2:0] snap_mdma;
		logic snap_trust;
		logic snap_pend;
		logic [15:0] rdata;
	} state_s;

	state_s s_q;
	state_s s_d;
	string_if sif ();

	logic [31:0] sect;
	logic [15:0] word_val;
	logic is_str;
	logic [5:0] str_addr;

	ident_string_store u_store (
		.clk(clk),
		.rst(rst),
		.port(sif.store)
	);

	// strings are written through an index register
	assign sif.we = wr && addr == R_STRING;
	assign sif.waddr = s_q.str_idx;
	assign sif.wdata = wdata;
	assign sif.raddr = str_addr;

	always_comb begin
		case (s_q.cap)
			2'h0: sect = SECT_CAP0;
			2'h1: sect = SECT_CAP1;
			2'h2: sect = SECT_CAP2;
			default: sect = SECT_CAP3;
		endcase
	end

	// map word index onto the string store
	always_comb begin
		is_str = 1'b0;
		str_addr = 6'h0;
		if (addr >= W_SERIAL && addr < W_SERIAL + 8'(STR_SERIAL_W)) begin
			is_str = 1'b1;
			str_addr = 6'(addr - W_SERIAL);
		end else if (addr >= W_FW && addr < W_FW + 8'(STR_FW_W)) begin
			is_str = 1'b1;
			str_addr = 6'(addr - W_FW + 8'(STR_SERIAL_W));
		end else if (addr >= W_MODEL && addr < W_MODEL + 8'(STR_MODEL_W)) begin
			is_str = 1'b1;
			str_addr = 6'(addr - W_MODEL + 8'(STR_SERIAL_W + STR_FW_W));
		end
	end

	always_comb begin
		word_val = 16'h0000;
		if (is_str) begin
			word_val = sif.rdata;
		end else begin
			case (addr)
				W_MULT_MAX: word_val = V_MULT_MAX;
				W_TRUSTED: word_val = V_TRUSTED;
				W_CAP0: word_val = V_CAP0;
				W_CAP1: word_val = V_CAP1;
				W_VALID: word_val = V_VALID;
				W_SANITIZE: begin
					word_val = V_SANITIZE_FIX;
					word_val[B_SANITIZE] = ~s_q.snap_trust;
					word_val[B_MULT_VALID] = 1'b1;
					word_val[7:0] = s_q.snap_mult;
				end
				W_SECT_LO: word_val = sect[15:0];
				W_SECT_HI: word_val = sect[31:16];
				W_MDMA: begin
					word_val = V_MDMA_SUP;
					word_val[B_MDMA_SEL +: 3] = s_q.snap_mdma;
				end
				W_PIO: word_val = V_PIO;
				W_MDMA_MIN: word_val = V_CYCLE;
				W_MDMA_REC: word_val = V_CYCLE;
				W_PIO_MIN: word_val = V_CYCLE;
				W_PIO_RDY: word_val = V_CYCLE;
				W_ADDL: word_val = V_ADDL;
				W_QUEUE: word_val = V_QUEUE;
				R_CTRL: begin
					word_val[C_MULT +: 8] = s_q.mult;
					word_val[C_MDMA +: 3] = s_q.mdma;
					word_val[C_TRUST] = s_q.trust;
					word_val[C_CAP +: 2] = s_q.cap;
				end
				R_STRING: word_val[5:0] = s_q.str_idx;
				R_STATUS: begin
					word_val[0] = s_q.snap_pend;
					word_val[S_STR_IDX +: 6] = s_q.str_idx;
				end
				default: word_val = 16'h0000;
			endcase
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.rdata = 16'h0000;
		if (rd) begin
			s_d.rdata = word_val;
			// word 0 read opens a fresh block
			if (addr == W_CONFIG) begin
				s_d.snap_mult = s_q.mult;
				s_d.snap_mdma = s_q.mdma;
				s_d.snap_trust = s_q.trust;
				s_d.snap_pend = 1'b0;
			end
		end
		if (wr) begin
			case (addr)
				R_CTRL: begin
					s_d.mult = wdata[C_MULT +: 8];
					s_d.mdma = wdata[C_MDMA +: 3];
					s_d.trust = wdata[C_TRUST];
					s_d.cap = wdata[C_CAP +: 2];
					s_d.snap_pend = 1'b1;
					if (wdata[C_SNAP]) begin
						s_d.snap_mult = wdata[C_MULT +: 8];
						s_d.snap_mdma = wdata[C_MDMA +: 3];
						s_d.snap_trust = wdata[C_TRUST];
						s_d.snap_pend = 1'b0;
					end
				end
				R_STRING: s_d.str_idx = s_q.str_idx + 6'h1;
				R_STATUS: s_d.str_idx = wdata[S_STR_IDX +: 6];
				default: s_d.str_idx = s_q.str_idx;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{mult: RST_MULT, mdma: RST_MDMA, trust: 1'b0, cap: RST_CAP,
				str_idx: 6'h0, snap_mult: RST_MULT, snap_mdma: RST_MDMA,
				snap_trust: 1'b0, snap_pend: 1'b0, rdata: 16'h0000};
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
endmodule : ident_words

// *** ident_words_props.sv ***
// property checker for the identification word block
`timescale 1ns/1ps
module ident_words_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [ident_pkg::ADDR_W-1:0] addr,
	input wire logic [ident_pkg::WORD_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [ident_pkg::WORD_W-1:0] rdata
);
	import ident_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence read_of(logic [7:0] w);
		rd && addr == w;
	endsequence
	property word_is(logic [7:0] w, logic [15:0] v);
		read_of(w) |=> rdata == v;
	endproperty
	a_mult_max: assert property (word_is(8'h2f, 16'h8010)) else $error("bad word 47");
	a_trusted_word: assert property (word_is(8'h30, 16'h4001)) else $error("bad word 48");
	a_cap_word: assert property (word_is(8'h31, 16'h2f00)) else $error("bad word 49");
	a_cap_hi_word: assert property (word_is(8'h32, 16'h4001)) else $error("bad word 50");
	a_valid_word: assert property (word_is(8'h35, 16'h0006)) else $error("bad word 53");
	a_pio_word: assert property (word_is(8'h40, 16'h0003)) else $error("bad word 64");
	a_addl_word: assert property (word_is(8'h45, 16'h4000)) else $error("bad word 69");
	a_queue_word: assert property (word_is(8'h4b, 16'h001f)) else $error("bad word 75");
	a_cycle_words: assert property (rd && addr inside {[8'h41:8'h44]} |=> rdata == 16'h0078)
		else $error("bad cycle time word");
	a_erase_bits: assert property (read_of(8'h3b) |=> rdata[15:13] == 3'b111 && rdata[11:8] == 4'h1)
		else $error("bad word 59 fixed bits");
	a_mdma_bits: assert property (read_of(8'h3f) |=> $onehot0(rdata[10:8]) && rdata[7:0] == 8'h07)
		else $error("bad word 63");
	a_trust_clear: assert property (wr && addr == 8'h80 && wdata[15] && wdata[11] ##2 read_of(8'h3b) |=> !rdata[12])
		else $error("sanitize bit set in trusted mode");
	a_idle_zero: assert property (!rd |=> rdata == 16'h0000) else $error("read data not idle");
endmodule : ident_words_props
bind ident_words ident_words_props props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata));

// *** string_if.sv ***
// string store access between the top and the store
`timescale 1ns/1ps
interface string_if;
	logic we;
	logic [5:0] waddr;
	logic [15:0] wdata;
	logic [5:0] raddr;
	logic [15:0] rdata;
	modport owner (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : string_if

// *** tb.sv ***
// self-checking bench for the identification word block
`timescale 1ns/1ps
module tb;
	import ident_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] got;
	logic wr;
	logic rd;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int mult = 16, mdma = 0, trust = 0, cap = 0;
	int c_mult = 16, c_mdma = 0, c_trust = 0;
	int pend = 0, idx = 0;
	int str[34];
	int sect[4] = '{SECT_CAP0, SECT_CAP1, SECT_CAP2, SECT_CAP3};
	int var_w[4] = '{59, 60, 61, 63};
	always #12.5 clk = ~clk;
	ident_words dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	function automatic int exp_word(int w);
		case (w)
			47: return 16'h8010;
			48, 50: return 16'h4001;
			49: return 16'h2f00;
			53: return 16'h0006;
			59: return 16'he100 | (trust ? 0 : 16'h1000) | mult;
			60: return sect[cap] & 16'hffff;
			61: return sect[cap] >> 16;
			63: return 16'h0007 | (mdma << 8);
			64: return 16'h0003;
			65, 66, 67, 68: return 16'h0078;
			69: return 16'h4000;
			75: return 16'h001f;
			128: return c_mult | (c_mdma << 8) | (c_trust << 11) | (cap << 12);
			129: return idx;
			130: return pend | (idx << 5);
			default: begin
				if (w >= 10 && w < 20) return str[w - 10];
				if (w >= 23 && w < 47) return str[w - 13];
				return 0;
			end
		endcase
	endfunction : exp_word
	task automatic chk(input int w);
		host.get(w[7:0], got);
		tests_run++;
		if (got !== 16'(exp_word(w))) begin
			bad_count++;
			$display("Error word %0d expected %h seen %h", w, 16'(exp_word(w)), got);
		end
		// reading word 0 latches the variable fields
		if (w == 0) begin
			mult = c_mult;
			mdma = c_mdma;
			trust = c_trust;
			pend = 0;
		end
	endtask : chk
	task automatic ctl(input int m, input int d, input int t, input int c, input int s);
		host.put(R_CTRL, 16'((s << 15) | (c << 12) | (t << 11) | (d << 8) | m));
		c_mult = m;
		c_mdma = d;
		c_trust = t;
		cap = c;
		pend = (s == 0) ? 1 : 0;
		if (s != 0) begin
			mult = m;
			mdma = d;
			trust = t;
		end
	endtask : ctl
	task automatic report_and_stop;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'hd04e_1105));
		foreach (str[i]) str[i] = 16'h2020;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int w = 0; w < 80; w++) begin
			chk(w);
		end
		for (int c = 0; c < 4; c++) begin
			ctl($urandom_range(16, 1), 1 << (c % 3), c % 2, c, 1);
			foreach (var_w[i]) chk(var_w[i]);
		end
		ctl(5, 2, 1, 2, 0);
		chk(128);
		chk(130);
		chk(59);
		chk(63);
		chk(0);
		chk(130);
		chk(59);
		chk(63);
		host.put(R_STATUS, 16'h0000);
		idx = 0;
		for (int i = 0; i < 34; i++) begin
			str[i] = $urandom_range(16'h7e7e, 16'h2020);
			host.put(R_STRING, 16'(str[i]));
			idx++;
		end
		chk(129);
		chk(130);
		for (int w = 10; w < 47; w++) chk(w);
		host.put(8'h2f, 16'h0000);
		chk(47);
		chk(192);
		report_and_stop();
	end
endmodule : tb
